/* File: hw/rtsm_pkg.sv */
`default_nettype none

package rtsm_pkg;

   // Special function register addresses.
   localparam logic [7:0] ADDR_TIMER_CONTROL = 8'hC8;
   localparam logic [7:0] ADDR_RELOAD_LOW_BYTE = 8'hCA;
   localparam logic [7:0] ADDR_RELOAD_HIGH_BYTE = 8'hCB;
   localparam logic [7:0] ADDR_COUNT_LOW_BYTE = 8'hCC;
   localparam logic [7:0] ADDR_COUNT_HIGH_BYTE = 8'hCD;
   localparam logic [7:0] ADDR_UNMAPPED_DATA = 8'h00;

   // Bit positions inside the control register.
   localparam int BIT_HIGH_OVERFLOW_FLAG = 7;
   localparam int BIT_LOW_OVERFLOW_FLAG = 6;
   localparam int BIT_LOW_INTERRUPT_ENABLE = 5;
   localparam int BIT_SPLIT_MODE_SELECT = 3;
   localparam int BIT_RUN_CONTROL = 2;
   localparam int BIT_EXTERNAL_CLOCK_SELECT = 0;

   // Values after reset.
   localparam logic [7:0] RESET_TIMER_CONTROL = 8'h00;
   localparam logic [7:0] RESET_RELOAD_BYTE = 8'h00;
   localparam logic [7:0] RESET_COUNT_BYTE = 8'h00;

   // Byte and word extremes of the counters.
   localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
   localparam logic [15:0] WORD_ALL_ONES = 16'hFFFF;

   // Clock source dividers, in core clock cycles or oscillator edges.
   localparam int CORE_DIVIDE = 12;
   localparam logic [3:0] CORE_DIVIDE_LAST = 4'(CORE_DIVIDE - 1);
   localparam int EXT_DIVIDE = 8;
   localparam logic [2:0] EXT_DIVIDE_LAST = 3'(EXT_DIVIDE - 1);

endpackage : rtsm_pkg

`default_nettype wire

/* File: hw/rtsm_timer.sv */
// How it works
// - High flag set on upper byte wrap.
// - Combined mode: high flag on 16-bit wrap.
// - Enabled timer interrupt follows set high flag.
// - Hardware never clears either overflow flag.
// - Low flag set on lower byte wrap.
// - Low enable adds lower byte overflow interrupt.
// - Control bits 4, 1 read zero.
// - Split bit picks 16-bit or 8-bit pairs.
// - Run bit gates combined 16-bit counter.
// - Split: run gates upper, lower runs free.
// - External select: core/12 or oscillator/8 synchronised.
// - External select shared; byte select overrides.
// - Low reload byte, read/write, resets zero.
// - High reload byte, read/write, resets zero.
// - Combined wrap reloads counter, sets high flag.
// - Split: each byte reloads from own byte.
// - Byte select 1 chooses undivided core clock.
// - Split: upper interrupts when timer interrupt enabled, lower also needs low enable.
`timescale 1ns/100ps
`default_nettype none

module rtsm_timer (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_sfr_addr,
   input wire logic i_sfr_wr,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic i_ext_osc,
   input wire logic i_timer_int_enable,
   input wire logic i_high_byte_clock_select,
   input wire logic i_low_byte_clock_select,
   output logic [7:0] o_sfr_rdata,
   output logic o_timer_irq
);

   logic ext_s1_q, ext_s2_q, ext_s3_q;
   logic [2:0] ext_div_q, ext_div_d;
   logic [3:0] pre_q, pre_d;
   logic tick_core12, tick_ext8, tick_low, tick_high;
   logic high_flag_q, high_flag_d, low_flag_q, low_flag_d;
   logic low_int_en_q, low_int_en_d, split_q, split_d;
   logic run_q, run_d, xclk_q, xclk_d;
   logic [7:0] reload_low_q, reload_low_d, reload_high_q, reload_high_d;
   logic [7:0] count_low_q, count_low_d, count_high_q, count_high_d;
   logic [15:0] count_inc;
   logic set_high, set_low;
   logic wr_ctrl, wr_rl, wr_rh, wr_cl, wr_ch;
   logic [7:0] rdata_d;
   logic irq_d;

   // Oscillator pin synchroniser; the third stage only serves edge detection.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
      end else begin
         ext_s1_q <= i_ext_osc;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end

   // Dividers for the core clock by twelve and the oscillator by eight.
   // clock source dividers
   always_comb begin
      pre_d = (pre_q == rtsm_pkg::CORE_DIVIDE_LAST) ? 4'h0 : pre_q + 4'h1;
      ext_div_d = ext_div_q;
      if (ext_s2_q && !ext_s3_q) begin
         ext_div_d = ext_div_q + 3'h1;
      end
      tick_core12 = (pre_q == rtsm_pkg::CORE_DIVIDE_LAST);
      tick_ext8 = ext_s2_q && !ext_s3_q && (ext_div_q == rtsm_pkg::EXT_DIVIDE_LAST);
   end

   // Divider state.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         pre_q <= 4'h0;
         ext_div_q <= 3'h0;
      end else begin
         pre_q <= pre_d;
         ext_div_q <= ext_div_d;
      end
   end

   // Per-byte tick choice; the low byte select also drives the 16-bit mode.
   // source override
   always_comb begin
      tick_low = i_low_byte_clock_select ? 1'b1 : (xclk_q ? tick_ext8 : tick_core12);
      tick_high = i_high_byte_clock_select ? 1'b1 : (xclk_q ? tick_ext8 : tick_core12);
   end

   // Write strobes decoded from the register address.
   always_comb begin
      wr_ctrl = i_sfr_wr && (i_sfr_addr == rtsm_pkg::ADDR_TIMER_CONTROL);
      wr_rl = i_sfr_wr && (i_sfr_addr == rtsm_pkg::ADDR_RELOAD_LOW_BYTE);
      wr_rh = i_sfr_wr && (i_sfr_addr == rtsm_pkg::ADDR_RELOAD_HIGH_BYTE);
      wr_cl = i_sfr_wr && (i_sfr_addr == rtsm_pkg::ADDR_COUNT_LOW_BYTE);
      wr_ch = i_sfr_wr && (i_sfr_addr == rtsm_pkg::ADDR_COUNT_HIGH_BYTE);
   end

   // Counting, reload and overflow detection; a software count write wins.
   always_comb begin
      count_low_d = count_low_q;
      count_high_d = count_high_q;
      set_high = 1'b0;
      set_low = 1'b0;
      count_inc = {count_high_q, count_low_q} + 16'h0001;
      if (!split_q) begin
         if (run_q && tick_low) begin
            if ({count_high_q, count_low_q} == rtsm_pkg::WORD_ALL_ONES) begin
               count_low_d = reload_low_q;
               count_high_d = reload_high_q;
               set_high = 1'b1;
               set_low = 1'b1;
            end else begin
               count_low_d = count_inc[7:0];
               count_high_d = count_inc[15:8];
               set_low = (count_low_q == rtsm_pkg::BYTE_ALL_ONES);
            end
         end
      end else begin
         if (tick_low) begin
            if (count_low_q == rtsm_pkg::BYTE_ALL_ONES) begin
               count_low_d = reload_low_q;
               set_low = 1'b1;
            end else begin
               count_low_d = count_low_q + 8'h01;
            end
         end
         if (run_q && tick_high) begin
            if (count_high_q == rtsm_pkg::BYTE_ALL_ONES) begin
               count_high_d = reload_high_q;
               set_high = 1'b1;
            end else begin
               count_high_d = count_high_q + 8'h01;
            end
         end
      end
      if (wr_cl) begin
         count_low_d = i_sfr_wdata;
      end
      if (wr_ch) begin
         count_high_d = i_sfr_wdata;
      end
   end

   // Count byte state.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         count_low_q <= rtsm_pkg::RESET_COUNT_BYTE;
         count_high_q <= rtsm_pkg::RESET_COUNT_BYTE;
      end else begin
         count_low_q <= count_low_d;
         count_high_q <= count_high_d;
      end
   end

   // Control and reload registers; unused control bits are not stored.
   always_comb begin
      high_flag_d = set_high || (wr_ctrl ? i_sfr_wdata[rtsm_pkg::BIT_HIGH_OVERFLOW_FLAG]
                                         : high_flag_q);
      low_flag_d = set_low || (wr_ctrl ? i_sfr_wdata[rtsm_pkg::BIT_LOW_OVERFLOW_FLAG]
                                       : low_flag_q);
      low_int_en_d = wr_ctrl ? i_sfr_wdata[rtsm_pkg::BIT_LOW_INTERRUPT_ENABLE] : low_int_en_q;
      split_d = wr_ctrl ? i_sfr_wdata[rtsm_pkg::BIT_SPLIT_MODE_SELECT] : split_q;
      run_d = wr_ctrl ? i_sfr_wdata[rtsm_pkg::BIT_RUN_CONTROL] : run_q;
      xclk_d = wr_ctrl ? i_sfr_wdata[rtsm_pkg::BIT_EXTERNAL_CLOCK_SELECT] : xclk_q;
      reload_low_d = wr_rl ? i_sfr_wdata : reload_low_q;
      reload_high_d = wr_rh ? i_sfr_wdata : reload_high_q;
   end

   // Control and reload state.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         high_flag_q <= rtsm_pkg::RESET_TIMER_CONTROL[rtsm_pkg::BIT_HIGH_OVERFLOW_FLAG];
         low_flag_q <= rtsm_pkg::RESET_TIMER_CONTROL[rtsm_pkg::BIT_LOW_OVERFLOW_FLAG];
         low_int_en_q <= rtsm_pkg::RESET_TIMER_CONTROL[rtsm_pkg::BIT_LOW_INTERRUPT_ENABLE];
         split_q <= rtsm_pkg::RESET_TIMER_CONTROL[rtsm_pkg::BIT_SPLIT_MODE_SELECT];
         run_q <= rtsm_pkg::RESET_TIMER_CONTROL[rtsm_pkg::BIT_RUN_CONTROL];
         xclk_q <= rtsm_pkg::RESET_TIMER_CONTROL[rtsm_pkg::BIT_EXTERNAL_CLOCK_SELECT];
         reload_low_q <= rtsm_pkg::RESET_RELOAD_BYTE;
         reload_high_q <= rtsm_pkg::RESET_RELOAD_BYTE;
      end else begin
         high_flag_q <= high_flag_d;
         low_flag_q <= low_flag_d;
         low_int_en_q <= low_int_en_d;
         split_q <= split_d;
         run_q <= run_d;
         xclk_q <= xclk_d;
         reload_low_q <= reload_low_d;
         reload_high_q <= reload_high_d;
      end
   end

   // Read data mux and interrupt request, both registered.
   always_comb begin
      unique case (i_sfr_addr)
         rtsm_pkg::ADDR_TIMER_CONTROL: begin
            rdata_d = {high_flag_q, low_flag_q, low_int_en_q, 1'b0,
                       split_q, run_q, 1'b0, xclk_q};
         end
         rtsm_pkg::ADDR_RELOAD_LOW_BYTE: rdata_d = reload_low_q;
         rtsm_pkg::ADDR_RELOAD_HIGH_BYTE: rdata_d = reload_high_q;
         rtsm_pkg::ADDR_COUNT_LOW_BYTE: rdata_d = count_low_q;
         rtsm_pkg::ADDR_COUNT_HIGH_BYTE: rdata_d = count_high_q;
         default: rdata_d = rtsm_pkg::ADDR_UNMAPPED_DATA;
      endcase
      irq_d = i_timer_int_enable && (high_flag_q || (low_int_en_q && low_flag_q));
   end

   // Output registers.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_sfr_rdata <= 8'h00;
         o_timer_irq <= 1'b0;
      end else begin
         o_sfr_rdata <= rdata_d;
         o_timer_irq <= irq_d;
      end
   end

   // Checks on the counting, flags, interrupt and register read-back.
   a_combined_high_flag: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      !split_q && run_q && tick_low && ({count_high_q, count_low_q} == 16'hFFFF)
      |=> high_flag_q && low_flag_q)
      else $error("combined wrap did not set both flags");

   a_combined_reload_value: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      !split_q && run_q && tick_low && ({count_high_q, count_low_q} == 16'hFFFF)
      && !wr_cl && !wr_ch && !wr_rl && !wr_rh
      |=> {count_high_q, count_low_q} == {$past(reload_high_q), $past(reload_low_q)})
      else $error("combined wrap did not load reload value");

   a_split_low_wrap: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      split_q && tick_low && (count_low_q == 8'hFF) && !wr_cl
      |=> low_flag_q && (count_low_q == $past(reload_low_q)))
      else $error("split low wrap missed flag or reload");

   a_flags_sticky: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      high_flag_q && low_flag_q && !wr_ctrl |=> high_flag_q && low_flag_q)
      else $error("overflow flag cleared without a write");

   a_high_irq_lag: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      i_timer_int_enable && high_flag_q |=> o_timer_irq)
      else $error("high flag did not raise interrupt");

   a_low_irq_gate: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      i_timer_int_enable && !high_flag_q && low_flag_q
      |=> o_timer_irq == $past(low_int_en_q))
      else $error("low interrupt not gated by low enable");

   a_unused_read_zero: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      i_sfr_addr == rtsm_pkg::ADDR_TIMER_CONTROL |=> !o_sfr_rdata[4] && !o_sfr_rdata[1])
      else $error("unused control bits read nonzero");

   a_split_low_free: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      split_q && !run_q && tick_low && !wr_cl && (count_low_q != 8'hFF)
      |=> count_low_q == $past(count_low_q) + 8'h01)
      else $error("split low byte stalled with run off");

   a_stopped_holds: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      !split_q && !run_q && !wr_cl && !wr_ch |=> $stable({count_high_q, count_low_q}))
      else $error("combined counter moved with run off");

   a_set_beats_clear: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      set_high && wr_ctrl && !i_sfr_wdata[7] |=> high_flag_q)
      else $error("software clear lost a hardware set");

   a_core_div_twelve: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      tick_core12 |-> ##12 tick_core12)
      else $error("core divide tick spacing not twelve");

endmodule : rtsm_timer

`default_nettype wire

/* File: testbench/test_reload_timer_split_mode.sv */
`timescale 1ns/100ps
`default_nettype none

module test_reload_timer_split_mode;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic wr = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic osc = 1'b0;
   logic int_en = 1'b0;
   logic hsel = 1'b0;
   logic lsel = 1'b0;
   logic [7:0] rdata;
   logic irq;
   logic [7:0] v;
   int bad_count = 0;
   int checks_done = 0;
   int cycles = 0;

   // Core clock with a 40 ns period.
   always #20 core_clk = ~core_clk;

   rtsm_timer rtsm_timer_i (
      .i_core_clk(core_clk),
      .i_rst(rst),
      .i_sfr_addr(addr),
      .i_sfr_wr(wr),
      .i_sfr_wdata(wdata),
      .i_ext_osc(osc),
      .i_timer_int_enable(int_en),
      .i_high_byte_clock_select(hsel),
      .i_low_byte_clock_select(lsel),
      .o_sfr_rdata(rdata),
      .o_timer_irq(irq)
   );

   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : wrap_up

   // Cuts a hang short after far more cycles than the tests need.
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         $display("[FAIL] timeout expected 20000 seen %0d", cycles);
         bad_count++;
         wrap_up();
      end
   end

   // Drops any write strobe left standing, then lets n cycles pass.
   task automatic idle(input int n);
      wr = 1'b0;
      repeat (n) @(negedge core_clk);
   endtask : idle

   // One write per rising edge; the strobe stays up so back-to-back writes never
   // lower and raise it in one time step, and the next read or idle drops it.
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge core_clk);
   endtask : wr_reg

   // The read data follows the address one edge later.
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      wr = 1'b0;
      addr = a;
      @(negedge core_clk);
      d = rdata;
   endtask : rd_reg

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic chk_in(input string name, input logic [7:0] lo, input logic [7:0] hi,
                         input logic [7:0] got);
      checks_done++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         bad_count++;
         $display("[FAIL] %s expected %h..%h seen %h", name, lo, hi, got);
      end
   endtask : chk_in

   // Reset values of every register and the request line.
   task automatic t_reset();
      logic [7:0] a [5] = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD};
      foreach (a[i]) begin
         rd_reg(a[i], v);
         chk("reset_value", 8'h00, v);
      end
      chk("irq_reset", 8'h00, {7'h00, irq});
   endtask : t_reset

   // Reload bytes, unused control bits and an unmapped address.
   task automatic t_regs();
      wr_reg(8'hCA, 8'hA5);
      rd_reg(8'hCA, v);
      chk("reload_low", 8'hA5, v);
      wr_reg(8'hCB, 8'h5A);
      rd_reg(8'hCB, v);
      chk("reload_high", 8'h5A, v);
      wr_reg(8'hC8, 8'hFF);
      rd_reg(8'hC8, v);
      chk("control_unused", 8'hED, v);
      wr_reg(8'hC8, 8'h00);
      wr_reg(8'hC9, 8'h77);
      rd_reg(8'hC9, v);
      chk("unmapped", 8'h00, v);
   endtask : t_regs

   // Sixteen-bit wrap, reload, flags held, interrupt and run gating.
   task automatic t_combined();
      int_en = 1'b1;
      lsel = 1'b1;
      wr_reg(8'hCD, 8'hFF);
      wr_reg(8'hCC, 8'hFE);
      wr_reg(8'hCA, 8'h34);
      wr_reg(8'hCB, 8'h12);
      wr_reg(8'hC8, 8'h04);
      idle(1);
      // This flag-clearing write lands on the very edge of the 16-bit wrap.
      wr_reg(8'hC8, 8'h04);
      idle(8);
      rd_reg(8'hCD, v);
      chk("wrap_reload_high", 8'h12, v);
      rd_reg(8'hC8, v);
      chk("wrap_flags", 8'hC4, v);
      chk("irq_high", 8'h01, {7'h00, irq});
      idle(20);
      rd_reg(8'hC8, v);
      chk("flags_held", 8'hC4, v);
      wr_reg(8'hC8, 8'h04);
      idle(2);
      chk("irq_cleared", 8'h00, {7'h00, irq});
      rd_reg(8'hC8, v);
      chk("flags_cleared", 8'h04, v);
      wr_reg(8'hC8, 8'h00);
      // Reload 0x1234 plus 36 ticks up to the stopping write gives 0x1258.
      rd_reg(8'hCC, v);
      chk("stopped_at", 8'h58, v);
      idle(20);
      rd_reg(8'hCC, v);
      chk("stopped", 8'h58, v);
   endtask : t_combined

   // Split mode: free lower byte, gated upper byte, per-byte reloads.
   task automatic t_split();
      // Upper byte on the undivided clock, so its wrap comes within a few cycles.
      hsel = 1'b1;
      wr_reg(8'hC8, 8'h08);
      wr_reg(8'hCA, 8'hF0);
      wr_reg(8'hCB, 8'h80);
      wr_reg(8'hCD, 8'hFE);
      wr_reg(8'hCC, 8'hFE);
      idle(6);
      rd_reg(8'hCD, v);
      chk("upper_gated", 8'hFE, v);
      rd_reg(8'hC8, v);
      chk("low_flag", 8'h48, v);
      rd_reg(8'hCC, v);
      chk_in("low_reload", 8'hF0, 8'hFF, v);
      chk("irq_low_masked", 8'h00, {7'h00, irq});
      wr_reg(8'hC8, 8'h68);
      idle(2);
      chk("irq_low_enabled", 8'h01, {7'h00, irq});
      wr_reg(8'hC8, 8'h0C);
      idle(4);
      rd_reg(8'hCD, v);
      chk_in("high_reload", 8'h80, 8'h8F, v);
      rd_reg(8'hC8, v);
      chk("high_flag", 8'h8C, v & 8'hBF);
      chk("irq_upper", 8'h01, {7'h00, irq});
      wr_reg(8'hC8, 8'h00);
   endtask : t_split

   // Core divided by 12, oscillator divided by 8, per-byte override.
   task automatic t_clock();
      lsel = 1'b0;
      int_en = 1'b0;
      wr_reg(8'hCD, 8'h00);
      wr_reg(8'hCC, 8'h00);
      wr_reg(8'hC8, 8'h04);
      idle(120);
      rd_reg(8'hCC, v);
      chk_in("core_div12", 8'h09, 8'h0B, v);
      wr_reg(8'hC8, 8'h00);
      wr_reg(8'hCC, 8'h00);
      wr_reg(8'hC8, 8'h05);
      repeat (64) begin
         osc = 1'b1;
         idle(2);
         osc = 1'b0;
         idle(2);
      end
      idle(6);
      rd_reg(8'hCC, v);
      chk_in("osc_div8", 8'h07, 8'h08, v);
      wr_reg(8'hCC, 8'h10);
      wr_reg(8'hCD, 8'h10);
      hsel = 1'b1;
      wr_reg(8'hC8, 8'h0D);
      idle(10);
      rd_reg(8'hCC, v);
      chk("low_on_osc", 8'h10, v);
      rd_reg(8'hCD, v);
      chk_in("high_on_core", 8'h18, 8'h1F, v);
      wr_reg(8'hC8, 8'h00);
   endtask : t_clock

   // Reset for four cycles, then every scenario in turn.
   initial begin
      repeat (4) @(negedge core_clk);
      rst = 1'b0;
      @(negedge core_clk);
      t_reset();
      t_regs();
      t_combined();
      t_split();
      t_clock();
      wrap_up();
   end
endmodule : test_reload_timer_split_mode

`default_nettype wire
